// ==== tcs_seq.sv ====
// tcs_seq: sequence engine that walks a timestamped event list, either
// on its own frame count or chasing external timecode, plus the device
// end of the packetised download. assumes frame ticks and timecode come
// from logic on the same clock; serial download bytes come from an uart.
//
// Contract
// - free mode runs immediately on start
// - chase start only arms until timecode passes
// - current frame is timecode minus start time
// - jump only when skip exceeds tolerance
// - on jump rewind, seek first event not earlier
// - seeking passes events without executing them
// - scrub mode stops only on reset
// - stop-on-jump halts at last event or jump
// - restart needs timecode below start plus start
// - chase modes ignore loop and restart options
// - link carries 9-bit default or 8-bit
// - sequence time starts at one, +1 per tick
// - events at or before current frame run now
`timescale 1ns/1ps
module tcs_seq #(
  parameter int PKT_LEN = tcs_pkg::PKT_BYTES,
  parameter int RESP_CYC = tcs_pkg::RESP_WAIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_frame_tick,
  input wire logic i_start,
  input wire logic i_reset_cmd,
  input wire tcs_pkg::tcs_mode_e i_mode,
  input wire logic i_loop_en,
  input wire logic i_restart_en,
  input wire logic [tcs_pkg::FRAME_W-1:0] i_start_frame,
  input wire logic [tcs_pkg::FRAME_W-1:0] i_tc_frame,
  input wire logic i_tc_valid,
  input wire logic [7:0] i_tolerance,
  output logic [tcs_pkg::IDX_W-1:0] o_ev_idx,
  input wire tcs_pkg::tcs_event_s i_ev,
  output logic o_exec_valid,
  input wire logic i_exec_ready,
  output tcs_pkg::tcs_exec_s o_exec,
  output tcs_pkg::tcs_state_e o_state,
  output logic [tcs_pkg::FRAME_W-1:0] o_cur_frame,
  output logic o_jump,
  input wire logic i_dl_mode8,
  input wire logic i_rx_valid,
  input wire logic [8:0] i_rx_char,
  output logic o_wr_en,
  output logic [15:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic o_ack
);
  import tcs_pkg::*;

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  tcs_state_e st_r, st_nxt;
  logic [FRAME_W-1:0] frame_r, frame_nxt;
  logic [FRAME_W-1:0] last_tc_r;
  logic tc_seen_r;
  logic [IDX_W-1:0] idx_r, idx_nxt;
  logic done_r, done_nxt; // list played out in scrub mode
  logic in_ready;

  // chase arithmetic in frames
  wire chase = (i_mode != TCS_MODE_FREE);
  wire tc_past = i_tc_valid && (i_tc_frame > i_start_frame);
  wire tc_below = i_tc_valid && (i_tc_frame < i_start_frame);
  wire [FRAME_W-1:0] tc_rel = i_tc_frame - i_start_frame;
  wire [FRAME_W-1:0] tc_exp = last_tc_r + FRAME_FIRST;
  wire [FRAME_W-1:0] tc_fwd = i_tc_frame - tc_exp;
  wire [FRAME_W-1:0] tc_back = tc_exp - i_tc_frame;
  wire [FRAME_W-1:0] tol_w = {{(FRAME_W-8){1'b0}}, i_tolerance};
  wire tc_skip = (i_tc_frame >= tc_exp) ? (tc_fwd > tol_w)
                                        : (tc_back > tol_w);
  // jump only past the dropout tolerance
  wire jump = chase && i_tc_valid && tc_seen_r && tc_skip;

  // event due at or before the current frame
  wire ev_due = (i_ev.time_f <= frame_r);
  wire ev_reached = (i_ev.time_f >= frame_r);
  // a played-out scrub list is not executed again until a jump rewinds it
  wire fire = (st_r == TCS_ST_RUN) && ev_due && in_ready && !jump
              && !done_r;
  // loop/restart only honoured in free mode
  wire relaunch = !chase && (i_loop_en || i_restart_en);

  assign o_ev_idx = idx_r;
  assign o_state = st_r;
  assign o_cur_frame = frame_r;
  assign o_jump = jump;

  // next state and counters
  always_comb begin
    st_nxt = st_r;
    frame_nxt = frame_r;
    idx_nxt = idx_r;
    done_nxt = done_r;
    case (st_r)
      TCS_ST_IDLE: begin
        if (i_start && !chase) begin
          st_nxt = TCS_ST_RUN;
          frame_nxt = FRAME_FIRST;
          idx_nxt = IDX_ZERO;
        end else if (i_start) begin
          st_nxt = TCS_ST_ARMED;
          idx_nxt = IDX_ZERO;
        end
      end
      TCS_ST_ARMED: begin
        if (tc_past) begin
          st_nxt = TCS_ST_RUN;
          frame_nxt = tc_rel;
        end
      end
      TCS_ST_RUN: begin
        if (jump && i_mode == TCS_MODE_STOPJ) begin
          st_nxt = TCS_ST_HALT;
        end else if (jump) begin
          st_nxt = TCS_ST_SEEK;
          done_nxt = 1'b0;
          idx_nxt = IDX_ZERO;
          frame_nxt = tc_rel;
        end else begin
          if (chase && i_tc_valid) frame_nxt = tc_rel;
          else if (!chase && i_frame_tick) frame_nxt = frame_r + FRAME_FIRST;
          if (fire && i_ev.last) begin
            if (i_mode == TCS_MODE_STOPJ) begin
              st_nxt = TCS_ST_HALT;
            end else if (i_mode == TCS_MODE_SCRUB) begin
              st_nxt = TCS_ST_RUN;
              done_nxt = 1'b1; // keep running, no refire
            end else if (relaunch) begin
              idx_nxt = IDX_ZERO;
              frame_nxt = FRAME_FIRST;
            end else begin
              st_nxt = TCS_ST_IDLE;
            end
          end else if (fire) begin
            idx_nxt = idx_r + 8'h01;
          end
        end
      end
      TCS_ST_SEEK: begin
        // walk forward, nothing goes to the executor
        if (chase && i_tc_valid) frame_nxt = tc_rel;
        if (ev_reached || i_ev.last) st_nxt = TCS_ST_RUN;
        else idx_nxt = idx_r + 8'h01;
      end
      TCS_ST_HALT: begin
        if (i_start && tc_below) begin
          st_nxt = TCS_ST_ARMED;
          idx_nxt = IDX_ZERO;
        end
      end
      default: st_nxt = TCS_ST_IDLE;
    endcase
    if (i_reset_cmd) begin
      st_nxt = TCS_ST_IDLE;
      idx_nxt = IDX_ZERO;
      frame_nxt = FRAME_ZERO;
      done_nxt = 1'b0;
    end
  end

  // sequencer registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= TCS_ST_IDLE;
      frame_r <= FRAME_ZERO;
      idx_r <= IDX_ZERO;
      last_tc_r <= FRAME_ZERO;
      tc_seen_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      frame_r <= frame_nxt;
      idx_r <= idx_nxt;
      done_r <= done_nxt;
      if (i_tc_valid) last_tc_r <= i_tc_frame;
      if (i_tc_valid) tc_seen_r <= 1'b1;
    end
  end

  // executed events go through the two-entry buffer
  tcs_exec_s ex_in;
  assign ex_in.idx = idx_r;
  assign ex_in.data = i_ev.data;

  tcs_buf2 #(.W(EXEC_W)) u_buf (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_in_valid(fire),
    .o_in_ready(in_ready),
    .i_in_data(ex_in),
    .o_out_valid(o_exec_valid),
    .i_out_ready(i_exec_ready),
    .o_out_data(o_exec)
  );

  // ---------------------------------------------------------------
  // download receiver
  // ---------------------------------------------------------------
  logic [15:0] addr_r;
  logic [7:0] pcnt_r;
  logic wr_r;
  logic [7:0] wd_r;
  logic ack_r;
  logic [31:0] rwait_r;
  logic pend_r;

  // 9-bit mode: bit 8 marks packet start; 8-bit mode: raw byte stream
  wire mark9 = !i_dl_mode8 && i_rx_char[8];
  wire take = i_rx_valid && !mark9;
  wire pkt_done = take && (pcnt_r == 8'(PKT_LEN - 1));

  assign o_wr_en = wr_r;
  assign o_wr_addr = addr_r;
  assign o_wr_data = wd_r;
  assign o_ack = ack_r;

  // store bytes, answer once per packet well inside host timeout
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_r <= 16'h0000;
      pcnt_r <= 8'h00;
      wr_r <= 1'b0;
      wd_r <= 8'h00;
      ack_r <= 1'b0;
      rwait_r <= 32'h0;
      pend_r <= 1'b0;
    end else begin
      wr_r <= 1'b0;
      ack_r <= 1'b0;
      if (wr_r) addr_r <= addr_r + 16'h0001;
      if (i_rx_valid && mark9) begin
        pcnt_r <= 8'h00;
        addr_r <= {i_rx_char[7:0], 8'h00};
      end else if (take) begin
        wr_r <= 1'b1;
        wd_r <= i_rx_char[7:0];
        pcnt_r <= pkt_done ? 8'h00 : pcnt_r + 8'h01;
      end
      if (pkt_done) begin
        pend_r <= 1'b1;
        rwait_r <= 32'h0;
      end else if (pend_r) begin
        rwait_r <= rwait_r + 32'h1;
        if (rwait_r >= 32'(RESP_CYC - 1) || !i_rx_valid) begin
          pend_r <= 1'b0;
          ack_r <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_free_start;
    (st_r == TCS_ST_IDLE) && i_start && !chase && !i_reset_cmd;
  endsequence

  a_free_run_start: assert property (@(posedge i_clk) disable iff (!i_nrst)
    s_free_start |=> (st_r == TCS_ST_RUN && frame_r == FRAME_FIRST))
    else $error("free start did not run from frame one");
  a_chase_arm_only: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st_r == TCS_ST_ARMED) |-> !o_exec_valid || $past(o_exec_valid))
    else $error("event issued while only armed");
  a_chase_frame_calc: assert property (@(posedge i_clk)
    disable iff (!i_nrst)
    (st_r == TCS_ST_RUN && chase && i_tc_valid && !jump && !i_reset_cmd)
    |=> frame_r == $past(tc_rel))
    else $error("chase frame is not timecode minus start");
  a_jump_tol: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_tc_valid && i_tc_frame == last_tc_r + FRAME_FIRST) |-> !jump)
    else $error("jump flagged on normal timecode step");
  a_seek_no_exec: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st_r == TCS_ST_SEEK && !o_exec_valid) |=> !o_exec_valid)
    else $error("event executed while seeking");
  a_scrub_jump_seek: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st_r == TCS_ST_RUN && jump && i_mode == TCS_MODE_SCRUB && !i_reset_cmd)
    |=> (st_r == TCS_ST_SEEK && idx_r == IDX_ZERO))
    else $error("scrub jump did not rewind");
  a_scrub_no_stop: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st_r == TCS_ST_RUN && i_mode == TCS_MODE_SCRUB && !i_reset_cmd)
    |=> st_r != TCS_ST_IDLE && st_r != TCS_ST_HALT)
    else $error("scrub sequence stopped by itself");
  a_stopj_halt: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st_r == TCS_ST_RUN && i_mode == TCS_MODE_STOPJ && jump && !i_reset_cmd)
    |=> st_r == TCS_ST_HALT)
    else $error("stop-on-jump did not halt");
  a_halt_restart: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st_r == TCS_ST_HALT && !(i_start && tc_below)) |=>
    st_r == TCS_ST_HALT || st_r == TCS_ST_IDLE)
    else $error("halted sequence restarted without condition");
  a_free_tick: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st_r == TCS_ST_RUN && !chase && i_frame_tick && !(fire && i_ev.last)
     && !i_reset_cmd) |=> frame_r == $past(frame_r) + FRAME_FIRST)
    else $error("frame count did not advance by one");
  a_due_fires: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st_r == TCS_ST_RUN && ev_due && in_ready && !jump && !done_r)
    |-> fire)
    else $error("due event was not executed");
endmodule : tcs_seq

// ==== tcs_pkg.sv ====
// tcs_pkg: shared constants, types and structs for the timecode chase
// sequencer. assumes a 100 MHz system clock and a frame-rate tick input.
package tcs_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int FRAME_W = 24;
  localparam int IDX_W = 8;
  localparam int EVDATA_W = 16;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int PKT_BYTES = 128;          // bytes per download packet
  localparam int PKT_GAP_MS = 50;          // host gap between packets
  localparam int TIMEOUT_MS = 1000;        // host timeout, 1 second
  localparam int RESP_WAIT_MS = 1;         // device answer delay bound
  localparam int RESP_WAIT_CYC = RESP_WAIT_MS * CLK_MHZ * 1000;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [FRAME_W-1:0] FRAME_FIRST = 24'h000001;
  localparam logic [FRAME_W-1:0] FRAME_ZERO = 24'h000000;
  localparam logic [IDX_W-1:0] IDX_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TCS_MODE_FREE = 2'b00,
    TCS_MODE_SCRUB = 2'b01,
    TCS_MODE_STOPJ = 2'b10
  } tcs_mode_e;

  typedef enum logic [2:0] {
    TCS_ST_IDLE = 3'b000,
    TCS_ST_ARMED = 3'b001,
    TCS_ST_RUN = 3'b010,
    TCS_ST_SEEK = 3'b011,
    TCS_ST_HALT = 3'b100
  } tcs_state_e;

  // event as presented by the show memory
  typedef struct packed {
    logic [FRAME_W-1:0] time_f;
    logic [EVDATA_W-1:0] data;
    logic last;
  } tcs_event_s;

  // word leaving the sequencer toward the executor
  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [EVDATA_W-1:0] data;
  } tcs_exec_s;

  localparam int EXEC_W = IDX_W + EVDATA_W;

endpackage : tcs_pkg

// ==== tcs_buf2.sv ====
// tcs_buf2: two-entry buffer with valid/ready on both sides.
// assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module tcs_buf2 #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  logic [W-1:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  // full and empty flags from the occupancy count
  assign o_in_ready = (cnt_r != 2'h2);
  assign o_out_valid = (cnt_r != 2'h0);
  assign o_out_data = mem_r[rp_r];

  // storage and pointers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= i_in_data;
        wp_r <= ~wp_r;
      end
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  a_buf_no_ovf: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (cnt_r == 2'h2 && !pop) |=> (cnt_r == 2'h2))
    else $error("buffer count left full without a pop");
endmodule : tcs_buf2

// ==== tcs_show_model.sv ====
// tcs_show_model: show memory holding a fixed four-event list.
// assumes the sequencer reads it combinationally at o_ev_idx.
`timescale 1ns/1ps
module tcs_show_model (
  input wire logic [tcs_pkg::IDX_W-1:0] i_idx,
  output tcs_pkg::tcs_event_s o_ev
);
  import tcs_pkg::*;
  // times 2,2,5,8; reads past the end return a far, final entry
  always_comb begin
    o_ev.data = {8'ha0, i_idx};
    o_ev.last = (i_idx >= 8'h03);
    case (i_idx)
      8'h00, 8'h01: o_ev.time_f = 24'h000002;
      8'h02: o_ev.time_f = 24'h000005;
      8'h03: o_ev.time_f = 24'h000008;
      default: o_ev.time_f = 24'hffffff;
    endcase
  end
endmodule : tcs_show_model

// ==== tcs_seq_tb_top.sv ====
// tcs_seq_tb_top: sequencer bench; free run, both chase modes, download.
// assumes the show model above and a short device answer window.
`timescale 1ns/1ps
module tcs_seq_tb_top;
  import tcs_pkg::*;
  logic i_clk = 0, i_nrst = 0, tick = 0, start = 0, rcmd = 0;
  logic loop_en = 0, rst_en = 0, tcv = 0, ready = 1, m8 = 0, rxv = 0;
  logic [7:0] tol = 8'h03;
  tcs_mode_e mode = TCS_MODE_FREE;
  logic [23:0] sf = 24'h000064, tcf = 24'h000000;
  logic [8:0] rxc = 9'h000;
  logic [7:0] idx;
  tcs_event_s ev;
  tcs_exec_s ex, q[$];
  tcs_state_e st;
  logic exv, jmp, wr, ack;
  logic [23:0] cur;
  logic [15:0] wa, base;
  logic [7:0] wd;
  int n_mismatch = 0, compares = 0, n_wr = 0, n_ack = 0, k;

  tcs_seq #(.PKT_LEN(128), .RESP_CYC(20)) dut (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_frame_tick(tick), .i_start(start),
    .i_reset_cmd(rcmd), .i_mode(mode), .i_loop_en(loop_en),
    .i_restart_en(rst_en), .i_start_frame(sf), .i_tc_frame(tcf),
    .i_tc_valid(tcv), .i_tolerance(tol), .o_ev_idx(idx), .i_ev(ev),
    .o_exec_valid(exv), .i_exec_ready(ready), .o_exec(ex), .o_state(st),
    .o_cur_frame(cur), .o_jump(jmp), .i_dl_mode8(m8), .i_rx_valid(rxv),
    .i_rx_char(rxc), .o_wr_en(wr), .o_wr_addr(wa), .o_wr_data(wd),
    .o_ack(ack));
  tcs_show_model mem (.i_idx(idx), .o_ev(ev));

  // clock, 10 ns period
  initial forever #5 i_clk = ~i_clk;

  task automatic give_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc

  // one-cycle strobes driven on the falling edge
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
    cyc(2);
  endtask : pulse

  task automatic tc(input logic [23:0] f, input logic ej);
    tcf = f;
    tcv = 1;
    #1 chk("jump", ej, jmp);
    cyc(1);
    tcv = 0;
    cyc(3);
  endtask : tc

  // host side: one character, paced apart
  task automatic send(input logic [8:0] c);
    rxc = c;
    rxv = 1;
    cyc(1);
    rxv = 0;
    cyc(2);
  endtask : send

  task automatic do_reset;
    i_nrst = 0;
    cyc(6);
    i_nrst = 1;
    cyc(1);
  endtask : do_reset

  // executed events and writes are gathered on the sampling edge
  always @(posedge i_clk) begin
    if (exv && ready) q.push_back(ex);
    if (ack) n_ack++;
    if (wr) begin
      chk("wr_addr", base + 16'(n_wr), wa);
      chk("wr_data", 8'(n_wr) ^ 8'h5a, wd);
      n_wr++;
    end
  end

  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    do_reset();
    // free mode: run at once from frame 1, events due by frame
    pulse(start);
    chk("state", TCS_ST_RUN, st);
    chk("frame", 1, cur);
    chk("early", 0, q.size());
    pulse(tick);
    chk("frame", 2, cur);
    cyc(4);
    chk("due", 2, q.size());
    chk("idx1", 8'h01, q[1].idx);
    chk("data", 16'ha001, q[1].data);
    ready = 0;
    repeat (7) pulse(tick);
    chk("hold", 1, exv);
    chk("stall", 2, q.size());
    ready = 1;
    cyc(8);
    chk("drained", 4, q.size());
    for (k = 0; k < q.size(); k++) chk("order", k, q[k].idx);
    chk("state", TCS_ST_IDLE, st);
    // free mode with looping: the last event wraps to frame one
    loop_en = 1;
    pulse(start);
    repeat (7) pulse(tick);
    chk("loop", TCS_ST_RUN, st);
    chk("wrap", 1, cur);
    pulse(rcmd);
    loop_en = 0;
    // scrub-following chase
    q = {};
    mode = TCS_MODE_SCRUB;
    pulse(start);
    chk("state", TCS_ST_ARMED, st);
    tc(24'h000064, 0);
    chk("armed", TCS_ST_ARMED, st);
    chk("none", 0, q.size());
    tc(24'h000066, 0);
    chk("state", TCS_ST_RUN, st);
    chk("frame", 2, cur);
    tc(24'h000068, 0);
    chk("frame", 4, cur);
    tc(24'h00006d, 1);
    cyc(10);
    chk("after", 8'h03, q[q.size()-1].idx);
    chk("count", 3, q.size());
    cyc(20);
    chk("runs", 1, st != TCS_ST_IDLE);
    tc(24'h000066, 1);
    cyc(10);
    chk("rewind", 5, q.size());
    chk("first", 8'h00, q[3].idx);
    // a wider tolerance swallows a nine-frame skip
    tol = 8'h10;
    tc(24'h000070, 0);
    tol = 8'h03;
    chk("frame", 12, cur);
    pulse(rcmd);
    chk("state", TCS_ST_IDLE, st);
    // stop-on-jump chase, loop and restart asked for
    mode = TCS_MODE_STOPJ;
    loop_en = 1;
    rst_en = 1;
    pulse(start);
    // a jump seen while only armed is ignored
    tc(24'h000065, 1);
    tc(24'h00006e, 1);
    chk("state", TCS_ST_HALT, st);
    pulse(start);
    chk("refused", TCS_ST_HALT, st);
    // restart needs start and a below-start timecode together
    start = 1;
    tc(24'h000032, 1);
    start = 0;
    chk("state", TCS_ST_ARMED, st);
    q = {};
    for (k = 101; k < 111; k++) tc(24'(k), k == 101);
    chk("all", 4, q.size());
    chk("state", TCS_ST_HALT, st);
    // download, default 9-bit characters
    base = 16'h1200;
    send(9'h112);
    for (k = 0; k < 128; k++) send({1'b0, 8'(k) ^ 8'h5a});
    cyc(30);
    chk("writes", 128, n_wr);
    chk("ack", 1, n_ack);
    // download, 8-bit mode from address zero after reset
    do_reset();
    m8 = 1;
    base = 16'h0000;
    n_wr = 0;
    for (k = 0; k < 3; k++) send({1'b0, 8'(k) ^ 8'h5a});
    cyc(4);
    chk("writes8", 3, n_wr);
    give_verdict();
  end
endmodule : tcs_seq_tb_top
